//--- core/afd_defines.svh
// Register offsets, field positions and reset values of the ALU and flags datapath
`ifndef AFD_DEFINES_SVH
`define AFD_DEFINES_SVH

// Wishbone register byte offsets
`define AFD_REG_ACC 8'h00
`define AFD_REG_FLAGS 8'h04
`define AFD_REG_RESULT 8'h08

// Flag word bit positions
`define AFD_FLAG_CARRY 0
`define AFD_FLAG_ZERO 1
`define AFD_FLAG_BRANCH 2
`define AFD_FLAG_USER 3

// Result register fields
`define AFD_RES_C 4
`define AFD_RES_Z 5

// Reset values, and the zero nibble that the zero indication tests against
`define AFD_ACC_RST 4'h0
`define AFD_SF_RST 1'b1
`define AFD_NIBBLE_ZERO 4'h0

`endif

//--- core/afd_pkg.sv
// Types shared by the ALU and flags datapath and its users
`default_nettype none

package afd_pkg;

    // Operation selected by the instruction decoder
    typedef enum logic [4:0] {
        AFD_OP_NOP,
        AFD_OP_LOAD,
        AFD_OP_INPUT,
        AFD_OP_STORE,
        AFD_OP_ADD,
        AFD_OP_ADD_WITH_CARRY_OP,
        AFD_OP_REVERSE_SUBTRACT_WITH_CARRY_OP,
        AFD_OP_COMPARE_OP,
        AFD_OP_AND,
        AFD_OP_OR,
        AFD_OP_XOR,
        AFD_OP_INC,
        AFD_OP_DEC,
        AFD_OP_ROTATE_LEFT_THROUGH_CARRY,
        AFD_OP_ROTATE_RIGHT_THROUGH_CARRY,
        AFD_OP_COPY_CARRY_AND_SET_OP,
        AFD_OP_COPY_INVERTED_CARRY_AND_CLEAR_OP,
        AFD_OP_SET_GF,
        AFD_OP_CLR_GF,
        AFD_OP_TEST_GF,
        AFD_OP_BRANCH,
        AFD_OP_INT_ACK,
        AFD_OP_INTERRUPT_RETURN_OP
    } afd_op_t;

    // Complete registered state of the datapath
    typedef struct packed {
        logic [3:0] acc;
        logic carry_flag;
        logic zero_flag;
        logic branch_condition_flag;
        logic user_flag;
        logic [3:0] result;
        logic alu_carry;
        logic alu_zero;
        logic branch_taken;
        logic push_valid;
        logic [3:0] push_flags;
        logic done;
        logic ack;
        logic [31:0] rdata;
    } afd_state_t;

endpackage

`default_nettype wire

//--- core/afd_datapath.sv
// ALU, accumulator and condition flags with a Wishbone register window
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`include "afd_defines.svh"
`default_nettype none

module afd_datapath (
    input wire logic mclk, // Core clock, 250 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic instr_valid, // One-cycle strobe: execute instr_op now
    input wire afd_pkg::afd_op_t instr_op, // Operation from the decoder
    input wire logic [3:0] operand, // Memory, immediate or port nibble
    input wire logic [3:0] restore_flags, // Flags popped from stack for return
    output logic [3:0] acc_out, // Accumulator contents
    output logic [3:0] result_out, // Last ALU or move result
    output logic alu_carry_out, // Last carry indication
    output logic alu_zero_out, // Last zero indication
    output logic carry_flag, // Carry flag
    output logic zero_flag, // Zero flag
    output logic branch_condition_flag, // Branch-condition flag
    output logic user_flag, // General-purpose user flag
    output logic branch_taken, // Pulse: branch is taken
    output logic flags_push_valid, // Pulse: flags word to push on stack
    output logic [3:0] flags_push_data, // Flags word to push
    output logic instr_done, // Pulse: instruction completed
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o // Wishbone acknowledge
);

    afd_pkg::afd_state_t st_ff;
    afd_pkg::afd_state_t nxt_st;

    // ALU operand and result wires
    logic [3:0] alu_a;
    logic [3:0] alu_b;
    logic alu_cin;
    logic [4:0] alu_sum;
    logic [3:0] res;
    logic res_c;
    logic res_z;
    logic bus_req;
    logic bus_wr_lo;
    logic [3:0] flags_now;

    // Adder core: carry out of bit 3 lands in bit 4
    assign alu_sum = {1'b0, alu_a} + {1'b0, alu_b} + {4'h0, alu_cin};

    // New request not yet answered; ack drops the cycle after it is given
    assign bus_req = wb_cyc_i && wb_stb_i && !st_ff.ack;
    assign bus_wr_lo = bus_req && wb_we_i && wb_sel_i[0];

    assign flags_now = {st_ff.user_flag, st_ff.branch_condition_flag,
                        st_ff.zero_flag, st_ff.carry_flag};

    // Operand steering and result selection
    always_comb begin
        alu_a = st_ff.acc;
        alu_b = operand;
        alu_cin = 1'b0;
        res = alu_sum[3:0];
        res_c = alu_sum[4];
        case (instr_op)
            afd_pkg::AFD_OP_ADD_WITH_CARRY_OP: begin
                alu_cin = st_ff.carry_flag;
            end
            afd_pkg::AFD_OP_REVERSE_SUBTRACT_WITH_CARRY_OP: begin
                // Operand minus accumulator as operand plus inverted acc plus carry
                alu_a = operand;
                alu_b = ~st_ff.acc;
                alu_cin = st_ff.carry_flag;
            end
            afd_pkg::AFD_OP_COMPARE_OP: begin
                alu_a = operand;
                alu_b = ~st_ff.acc;
                alu_cin = 1'b1;
            end
            afd_pkg::AFD_OP_INC: begin
                alu_b = 4'h1;
            end
            afd_pkg::AFD_OP_DEC: begin
                alu_b = 4'hF; // Adding all ones: carry 1 means no borrow
            end
            afd_pkg::AFD_OP_AND: begin
                res = st_ff.acc & operand;
                res_c = 1'b0;
            end
            afd_pkg::AFD_OP_OR: begin
                res = st_ff.acc | operand;
                res_c = 1'b0;
            end
            afd_pkg::AFD_OP_XOR: begin
                res = st_ff.acc ^ operand;
                res_c = 1'b0;
            end
            afd_pkg::AFD_OP_ROTATE_LEFT_THROUGH_CARRY: begin
                res = {st_ff.acc[2:0], st_ff.carry_flag};
                res_c = st_ff.acc[3];
            end
            afd_pkg::AFD_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                res = {st_ff.carry_flag, st_ff.acc[3:1]};
                res_c = st_ff.acc[0];
            end
            afd_pkg::AFD_OP_LOAD, afd_pkg::AFD_OP_INPUT: begin
                res = operand;
                res_c = 1'b0;
            end
            afd_pkg::AFD_OP_STORE: begin
                res = st_ff.acc; // Value moved to data memory
                res_c = 1'b0;
            end
            default: begin
                res = alu_sum[3:0];
                res_c = alu_sum[4];
            end
        endcase
        res_z = (res == `AFD_NIBBLE_ZERO);
    end

    // Next state: instruction effects, then bus access
    always_comb begin
        nxt_st = st_ff; // Anything not named holds its value
        nxt_st.branch_taken = 1'b0;
        nxt_st.push_valid = 1'b0;
        nxt_st.done = 1'b0;
        nxt_st.ack = bus_req;
        nxt_st.rdata = 32'h0000_0000;

        if (instr_valid) begin
            nxt_st.done = 1'b1;
            case (instr_op)
                afd_pkg::AFD_OP_LOAD, afd_pkg::AFD_OP_INPUT: begin
                    nxt_st.acc = res;
                    nxt_st.result = res;
                    nxt_st.alu_carry = res_c;
                    nxt_st.alu_zero = res_z;
                    nxt_st.zero_flag = res_z;
                    nxt_st.branch_condition_flag = 1'b1;
                end
                afd_pkg::AFD_OP_STORE: begin
                    // Zero indication shown, but the zero flag is not a target here
                    nxt_st.result = res;
                    nxt_st.alu_carry = res_c;
                    nxt_st.alu_zero = res_z;
                    nxt_st.branch_condition_flag = 1'b1;
                end
                afd_pkg::AFD_OP_ADD, afd_pkg::AFD_OP_INC, afd_pkg::AFD_OP_AND,
                afd_pkg::AFD_OP_OR, afd_pkg::AFD_OP_XOR: begin
                    nxt_st.acc = res;
                    nxt_st.result = res;
                    nxt_st.alu_carry = res_c;
                    nxt_st.alu_zero = res_z;
                    nxt_st.zero_flag = res_z;
                    // Overflow of ADD or INC, or a zero AND, OR or XOR result, arms the next branch as a skip
                    nxt_st.branch_condition_flag =
                        (instr_op == afd_pkg::AFD_OP_AND || instr_op == afd_pkg::AFD_OP_OR
                         || instr_op == afd_pkg::AFD_OP_XOR) ? ~res_z : ~res_c;
                end
                afd_pkg::AFD_OP_DEC: begin
                    nxt_st.acc = res;
                    nxt_st.result = res;
                    nxt_st.alu_carry = res_c;
                    nxt_st.alu_zero = res_z;
                    nxt_st.zero_flag = res_z;
                    nxt_st.branch_condition_flag = res_c; // Clear on underflow
                end
                afd_pkg::AFD_OP_ADD_WITH_CARRY_OP, afd_pkg::AFD_OP_REVERSE_SUBTRACT_WITH_CARRY_OP,
                afd_pkg::AFD_OP_ROTATE_LEFT_THROUGH_CARRY, afd_pkg::AFD_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                    nxt_st.acc = res;
                    nxt_st.result = res;
                    nxt_st.alu_carry = res_c;
                    nxt_st.alu_zero = res_z;
                    nxt_st.carry_flag = res_c;
                    nxt_st.zero_flag = res_z;
                    nxt_st.branch_condition_flag = ~res_c;
                end
                afd_pkg::AFD_OP_COMPARE_OP: begin
                    // Accumulator and user flag untouched; only the carry, zero and branch flags and the result, carry and zero indications reflect the comparison
                    nxt_st.result = res;
                    nxt_st.alu_carry = res_c;
                    nxt_st.alu_zero = res_z;
                    nxt_st.carry_flag = res_c;
                    nxt_st.zero_flag = res_z;
                    nxt_st.branch_condition_flag = ~res_z;
                end
                afd_pkg::AFD_OP_COPY_CARRY_AND_SET_OP: begin
                    nxt_st.branch_condition_flag = st_ff.carry_flag;
                    nxt_st.carry_flag = 1'b1;
                end
                afd_pkg::AFD_OP_COPY_INVERTED_CARRY_AND_CLEAR_OP: begin
                    nxt_st.branch_condition_flag = ~st_ff.carry_flag;
                    nxt_st.carry_flag = 1'b0;
                end
                afd_pkg::AFD_OP_SET_GF: begin
                    nxt_st.user_flag = 1'b1;
                    nxt_st.branch_condition_flag = 1'b1;
                end
                afd_pkg::AFD_OP_CLR_GF: begin
                    nxt_st.user_flag = 1'b0;
                    nxt_st.branch_condition_flag = 1'b1;
                end
                afd_pkg::AFD_OP_TEST_GF: begin
                    nxt_st.branch_condition_flag = st_ff.user_flag;
                end
                afd_pkg::AFD_OP_BRANCH: begin
                    // Taken only on a set flag; the flag then returns to rest at 1
                    nxt_st.branch_taken = st_ff.branch_condition_flag;
                    nxt_st.branch_condition_flag = 1'b1;
                end
                afd_pkg::AFD_OP_INT_ACK: begin
                    nxt_st.push_valid = 1'b1;
                    nxt_st.push_flags = flags_now;
                end
                afd_pkg::AFD_OP_INTERRUPT_RETURN_OP: begin
                    nxt_st.carry_flag = restore_flags[`AFD_FLAG_CARRY];
                    nxt_st.zero_flag = restore_flags[`AFD_FLAG_ZERO];
                    nxt_st.branch_condition_flag = restore_flags[`AFD_FLAG_BRANCH];
                    nxt_st.user_flag = restore_flags[`AFD_FLAG_USER];
                end
                default: begin
                    nxt_st.done = 1'b1;
                end
            endcase
        end

        // Software writes override a same-cycle instruction so a debugger wins
        if (bus_wr_lo) begin
            case (wb_adr_i)
                `AFD_REG_ACC: begin
                    nxt_st.acc = wb_dat_i[3:0];
                end
                `AFD_REG_FLAGS: begin
                    nxt_st.carry_flag = wb_dat_i[`AFD_FLAG_CARRY];
                    nxt_st.zero_flag = wb_dat_i[`AFD_FLAG_ZERO];
                    nxt_st.branch_condition_flag = wb_dat_i[`AFD_FLAG_BRANCH];
                    nxt_st.user_flag = wb_dat_i[`AFD_FLAG_USER];
                end
                default: begin
                    nxt_st.rdata = 32'h0000_0000; // Unmapped or read-only: ignored
                end
            endcase
        end

        // Read data sampled from the state before this edge
        if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                `AFD_REG_ACC: begin
                    nxt_st.rdata = {28'h000_0000, st_ff.acc};
                end
                `AFD_REG_FLAGS: begin
                    nxt_st.rdata = {28'h000_0000, flags_now};
                end
                `AFD_REG_RESULT: begin
                    nxt_st.rdata = {26'h000_0000, st_ff.alu_zero, st_ff.alu_carry,
                                    st_ff.result};
                end
                default: begin
                    nxt_st.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // State register; carry, zero and user flags deliberately survive reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_ff.acc <= `AFD_ACC_RST;
            st_ff.branch_condition_flag <= `AFD_SF_RST;
            st_ff.result <= 4'h0;
            st_ff.alu_carry <= 1'b0;
            st_ff.alu_zero <= 1'b0;
            st_ff.branch_taken <= 1'b0;
            st_ff.push_valid <= 1'b0;
            st_ff.push_flags <= 4'h0;
            st_ff.done <= 1'b0;
            st_ff.ack <= 1'b0;
            st_ff.rdata <= 32'h0000_0000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign acc_out = st_ff.acc;
    assign result_out = st_ff.result;
    assign alu_carry_out = st_ff.alu_carry;
    assign alu_zero_out = st_ff.alu_zero;
    assign carry_flag = st_ff.carry_flag;
    assign zero_flag = st_ff.zero_flag;
    assign branch_condition_flag = st_ff.branch_condition_flag;
    assign user_flag = st_ff.user_flag;
    assign branch_taken = st_ff.branch_taken;
    assign flags_push_valid = st_ff.push_valid;
    assign flags_push_data = st_ff.push_flags;
    assign instr_done = st_ff.done;
    assign wb_dat_o = st_ff.rdata;
    assign wb_ack_o = st_ff.ack;

endmodule // afd_datapath

`default_nettype wire

//--- tb/afd_datapath_props.sv
// Port-level assertions for the ALU and flags datapath
`default_nettype none
module afd_datapath_props (
    input wire logic mclk, // Core clock
    input wire logic resetn, // Reset, active low
    input wire logic instr_valid, // Instruction strobe
    input wire afd_pkg::afd_op_t instr_op, // Operation
    input wire logic [3:0] operand, // Operand nibble
    input wire logic [3:0] acc_out, // Accumulator
    input wire logic carry_flag, // Carry flag
    input wire logic zero_flag, // Zero flag
    input wire logic branch_condition_flag, // Branch flag
    input wire logic user_flag, // User flag
    input wire logic branch_taken, // Branch pulse
    input wire logic flags_push_valid, // Push pulse
    input wire logic [3:0] flags_push_data, // Pushed flags
    input wire logic instr_done, // Completion pulse
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_we_i // Bus write
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bw;
    logic go;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // A bus write in the same edge overrides the instruction, so such edges are left out
    assign bw = wb_cyc_i & wb_stb_i & wb_we_i;
    assign go = instr_valid & ~bw;

    property p_done; instr_valid |=> instr_done; endproperty
    a_done: assert property (p_done) else $error("instruction not completed");
    property p_gf; !(instr_valid && instr_op inside {afd_pkg::AFD_OP_SET_GF,
        afd_pkg::AFD_OP_CLR_GF, afd_pkg::AFD_OP_INTERRUPT_RETURN_OP}) && !bw |=> $stable(user_flag); endproperty
    a_gf: assert property (p_gf) else $error("user flag changed");
    property p_load; go && instr_op == afd_pkg::AFD_OP_LOAD |=>
        acc_out == $past(operand) && zero_flag == (acc_out == 4'h0); endproperty
    a_load: assert property (p_load) else $error("load zero wrong");
    property p_add_with_carry_op; go && instr_op == afd_pkg::AFD_OP_ADD_WITH_CARRY_OP |=> {carry_flag, acc_out} ==
        $past(acc_out) + {1'b0, $past(operand)} + $past(carry_flag); endproperty
    a_add_with_carry_op: assert property (p_add_with_carry_op) else $error("add with carry wrong");
    property p_compare_op; go && instr_op == afd_pkg::AFD_OP_COMPARE_OP |=>
        carry_flag == ($past(operand) >= $past(acc_out)) && $stable(acc_out); endproperty
    a_compare_op: assert property (p_compare_op) else $error("compare wrong");
    property p_rotate_left_through_carry; go && instr_op == afd_pkg::AFD_OP_ROTATE_LEFT_THROUGH_CARRY |=>
        {carry_flag, acc_out} == {$past(acc_out), $past(carry_flag)}; endproperty
    a_rotate_left_through_carry: assert property (p_rotate_left_through_carry) else $error("rotate wrong");
    property p_tp; go && instr_op == afd_pkg::AFD_OP_COPY_CARRY_AND_SET_OP |=>
        branch_condition_flag == $past(carry_flag) && carry_flag; endproperty
    a_tp: assert property (p_tp) else $error("copy carry and set wrong");
    property p_tc; go && instr_op == afd_pkg::AFD_OP_COPY_INVERTED_CARRY_AND_CLEAR_OP |=>
        branch_condition_flag != $past(carry_flag) && !carry_flag; endproperty
    a_tc: assert property (p_tc) else $error("copy inverted carry wrong");
    property p_br; instr_valid && instr_op == afd_pkg::AFD_OP_BRANCH |=>
        branch_taken == $past(branch_condition_flag); endproperty
    a_br: assert property (p_br) else $error("branch decision wrong");
    property p_push; go && instr_op == afd_pkg::AFD_OP_INT_ACK |=> flags_push_valid &&
        flags_push_data == {$past(user_flag), $past(branch_condition_flag),
        $past(zero_flag), $past(carry_flag)}; endproperty
    a_push: assert property (p_push) else $error("flag push wrong");
    c_add_with_carry_op: cover property (go && instr_op == afd_pkg::AFD_OP_ADD_WITH_CARRY_OP);
    c_branch: cover property (branch_taken);
    c_push: cover property (flags_push_valid);
endmodule // afd_datapath_props

bind afd_datapath afd_datapath_props i_afd_datapath_props (.mclk, .resetn, .instr_valid,
    .instr_op, .operand, .acc_out, .carry_flag, .zero_flag, .branch_condition_flag,
    .user_flag, .branch_taken, .flags_push_valid, .flags_push_data, .instr_done,
    .wb_cyc_i, .wb_stb_i, .wb_we_i);
`default_nettype wire

//--- tb/afd_stack_model.sv
// Flag stack of the sequencer: saves on interrupt accept, returns on interrupt return
`default_nettype none
module afd_stack_model (
    input wire logic mclk, // Core clock
    input wire logic instr_valid, // Instruction strobe
    input wire afd_pkg::afd_op_t instr_op, // Operation
    input wire logic flags_push_valid, // Flags offered for saving
    input wire logic [3:0] flags_push_data, // Flags to save
    output logic [3:0] restore_flags // Top of stack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] stk[$];
    initial restore_flags = 4'h5;
    // Empty stack shows a changing value so a stale word is never mistaken for a saved one
    always @(posedge mclk) begin
        if (flags_push_valid === 1'b1) stk.push_back(flags_push_data);
        if (instr_valid === 1'b1 && instr_op == afd_pkg::AFD_OP_INTERRUPT_RETURN_OP && stk.size() > 0)
            void'(stk.pop_back());
        restore_flags <= (stk.size() > 0) ? stk[$] : ~restore_flags;
    end
endmodule // afd_stack_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the ALU and flags datapath
`include "afd_defines.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, resetn, instr_valid, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    afd_pkg::afd_op_t instr_op;
    logic [3:0] operand, restore_flags, acc_out, result_out, flags_push_data, wb_sel_i;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic alu_carry_out, alu_zero_out, carry_flag, zero_flag, branch_condition_flag;
    logic user_flag, branch_taken, flags_push_valid, instr_done;
    logic [13:0] n;
    logic [31:0] e;
    logic [13:0] iq[$];
    logic [31:0] bq[$];
    logic [3:0] mstk[$];
    logic [3:0] m_acc = 4'h0;
    logic [3:0] m_f = 4'h0; // Model flags: user, branch, zero, carry
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    afd_datapath i_afd_datapath (.mclk, .resetn, .instr_valid, .instr_op, .operand,
        .restore_flags, .acc_out, .result_out, .alu_carry_out, .alu_zero_out, .carry_flag,
        .zero_flag, .branch_condition_flag, .user_flag, .branch_taken, .flags_push_valid,
        .flags_push_data, .instr_done, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
    afd_stack_model i_afd_stack_model (.mclk, .instr_valid, .instr_op, .flags_push_valid,
        .flags_push_data, .restore_flags);

    // 250 MHz core clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Cut a hang short well past the expected run length
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared = n_compared + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Random opcode, stack operations left out so the stack stays balanced
    function automatic afd_pkg::afd_op_t rop();
        return afd_pkg::afd_op_t'($urandom_range(20, 0));
    endfunction

    // Issue one instruction and note the state it must leave behind
    task automatic ins(input afd_pkg::afd_op_t op, input logic [3:0] d);
        logic [4:0] s;
        logic [3:0] a;
        logic [1:0] w;
        logic cf, zf, sf, gf, br, pv;
        {gf, sf, zf, cf} = m_f;
        a = m_acc;
        s = {1'b0, a};
        {w, br, pv} = '0;
        case (op)
            afd_pkg::AFD_OP_LOAD, afd_pkg::AFD_OP_INPUT: {w, s, sf} = {2'b11, 1'b0, d, 1'b1};
            afd_pkg::AFD_OP_STORE: sf = 1'b1;
            afd_pkg::AFD_OP_ADD: {w, s} = {2'b11, a + {1'b0, d}};
            afd_pkg::AFD_OP_INC: {w, s} = {2'b11, a + 5'h01};
            afd_pkg::AFD_OP_DEC: {w, s} = {2'b11, a + 5'h0F};
            afd_pkg::AFD_OP_AND: {w, s} = {3'b110, a & d};
            afd_pkg::AFD_OP_OR: {w, s} = {3'b110, a | d};
            afd_pkg::AFD_OP_XOR: {w, s} = {3'b110, a ^ d};
            afd_pkg::AFD_OP_ADD_WITH_CARRY_OP: {w, s} = {2'b11, a + {1'b0, d} + cf};
            afd_pkg::AFD_OP_REVERSE_SUBTRACT_WITH_CARRY_OP: {w, s} = {2'b11, d + {1'b0, ~a} + cf};
            afd_pkg::AFD_OP_COMPARE_OP: {w, s} = {2'b01, d + {1'b0, ~a} + 5'h01};
            afd_pkg::AFD_OP_ROTATE_LEFT_THROUGH_CARRY: {w, s} = {2'b11, a, cf};
            afd_pkg::AFD_OP_ROTATE_RIGHT_THROUGH_CARRY: {w, s} = {2'b11, a[0], cf, a[3:1]};
            afd_pkg::AFD_OP_COPY_CARRY_AND_SET_OP: {sf, cf} = {cf, 1'b1};
            afd_pkg::AFD_OP_COPY_INVERTED_CARRY_AND_CLEAR_OP: {sf, cf} = {~cf, 1'b0};
            afd_pkg::AFD_OP_SET_GF: {gf, sf} = 2'b11;
            afd_pkg::AFD_OP_CLR_GF: {gf, sf} = 2'b01;
            afd_pkg::AFD_OP_TEST_GF: sf = gf;
            afd_pkg::AFD_OP_BRANCH: {br, sf} = {sf, 1'b1};
            afd_pkg::AFD_OP_INT_ACK: pv = 1'b1;
            afd_pkg::AFD_OP_INTERRUPT_RETURN_OP: {gf, sf, zf, cf} = mstk.pop_back();
            default: ;
        endcase
        if (w[1]) a = s[3:0];
        if (w[0]) zf = (s[3:0] == 4'h0);
        if (op inside {afd_pkg::AFD_OP_ADD, afd_pkg::AFD_OP_INC, afd_pkg::AFD_OP_ADD_WITH_CARRY_OP,
            afd_pkg::AFD_OP_REVERSE_SUBTRACT_WITH_CARRY_OP, afd_pkg::AFD_OP_ROTATE_LEFT_THROUGH_CARRY, afd_pkg::AFD_OP_ROTATE_RIGHT_THROUGH_CARRY}) sf = ~s[4];
        if (op inside {afd_pkg::AFD_OP_ADD_WITH_CARRY_OP, afd_pkg::AFD_OP_REVERSE_SUBTRACT_WITH_CARRY_OP, afd_pkg::AFD_OP_COMPARE_OP,
            afd_pkg::AFD_OP_ROTATE_LEFT_THROUGH_CARRY, afd_pkg::AFD_OP_ROTATE_RIGHT_THROUGH_CARRY}) cf = s[4];
        if (op == afd_pkg::AFD_OP_DEC) sf = s[4];
        if (op inside {afd_pkg::AFD_OP_AND, afd_pkg::AFD_OP_OR, afd_pkg::AFD_OP_XOR,
            afd_pkg::AFD_OP_COMPARE_OP}) sf = ~zf;
        if (pv) mstk.push_back(m_f);
        iq.push_back({a, gf, sf, zf, cf, br, pv, pv ? m_f : 4'h0});
        m_acc = a;
        m_f = {gf, sf, zf, cf};
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr_op <= op;
        operand <= d;
    endtask

    // One classic bus cycle; a read notes the word it must return
    task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] dt,
        input logic [3:0] sl, input logic [31:0] ex);
        if (!we) bq.push_back(ex);
        if (we && sl[0] && ad == `AFD_REG_ACC) m_acc = dt[3:0];
        if (we && sl[0] && ad == `AFD_REG_FLAGS) m_f = dt[3:0];
        @(posedge mclk);
        instr_valid <= 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= ad;
        wb_dat_i <= dt;
        wb_sel_i <= sl;
        @(posedge mclk);
        while (wb_ack_o !== 1'b1) @(posedge mclk);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic sum(input afd_pkg::afd_op_t op, input logic [3:0] a, d, input logic [31:0] ex);
        ins(afd_pkg::AFD_OP_LOAD, a);
        ins(op, d);
        wb(1'b0, `AFD_REG_RESULT, 32'h0, 4'hF, ex);
    endtask

    // Each result taken off its note as it shows at the ports
    always @(posedge mclk) begin
        if (instr_done === 1'b1) begin
            n = iq.pop_front();
            chk("acc", n[13:10], acc_out);
            chk("flags", n[9:6], {user_flag, branch_condition_flag, zero_flag, carry_flag});
            chk("branch", n[5], branch_taken);
            chk("push", n[4:0], {flags_push_valid, n[4] ? flags_push_data : 4'h0});
        end
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            e = bq.pop_front();
            chk("rdata", e, wb_dat_o);
            // Result ports must agree with the noted result word
            if (wb_adr_i == `AFD_REG_RESULT)
                chk("result", e, {26'h0, alu_zero_out, alu_carry_out, result_out});
        end
    end

    initial begin
        {resetn, instr_valid, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
        instr_op = afd_pkg::AFD_OP_NOP;
        {operand, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
        void'($urandom(62));
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        wb(1'b1, `AFD_REG_FLAGS, 32'h1, 4'hF, 32'h0);
        wb(1'b1, `AFD_REG_FLAGS, 32'hE, 4'hE, 32'h0);
        wb(1'b0, `AFD_REG_FLAGS, 32'h0, 4'hF, 32'h1);
        wb(1'b1, `AFD_REG_ACC, 32'hFFFF_FFF3, 4'hF, 32'h0);
        wb(1'b0, `AFD_REG_ACC, 32'h0, 4'hF, 32'h3);
        wb(1'b0, 8'h0C, 32'h0, 4'hF, 32'h0);
        sum(afd_pkg::AFD_OP_ADD_WITH_CARRY_OP, 4'hC, 4'h5, 32'h12);
        sum(afd_pkg::AFD_OP_REVERSE_SUBTRACT_WITH_CARRY_OP, 4'h8, 4'h5, 32'h0D);
        sum(afd_pkg::AFD_OP_ADD, 4'h7, 4'h9, 32'h30);
        for (int i = 0; i <= 20; i++) ins(afd_pkg::afd_op_t'(i), 4'($urandom));
        repeat (300) ins(rop(), 4'($urandom));
        for (int i = 0; i < 2; i++) begin
            ins(afd_pkg::AFD_OP_INT_ACK, 4'h0);
            repeat (3) ins(rop(), 4'($urandom));
        end
        repeat (2) begin
            ins(afd_pkg::AFD_OP_INTERRUPT_RETURN_OP, 4'h0);
            ins(rop(), 4'($urandom));
        end
        wb(1'b0, `AFD_REG_ACC, 32'h0, 4'hF, {28'h0, m_acc});
        // Mid-run reset: branch flag back to 1, the other flags keep their values
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        m_acc = 4'h0;
        m_f[2] = 1'b1;
        wb(1'b0, `AFD_REG_FLAGS, 32'h0, 4'hF, {28'h0, m_f});
        ins(afd_pkg::AFD_OP_BRANCH, 4'h0);
        wb(1'b0, `AFD_REG_ACC, 32'h0, 4'hF, 32'h0);
        repeat (3) @(posedge mclk);
        summarize();
    end
endmodule // testbench
`default_nettype wire
